/* File: burst_time_plan_parser.sv */
`timescale 1ns/100ps
module burst_time_plan_parser (
  // clock, reset, enable
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // section byte stream
  input  wire logic [7:0]  sec_data_i,
  input  wire logic        sec_valid_i,
  input  wire logic        sec_start_i,
  input  wire logic [12:0] sec_pid_i,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // status
  output logic             plan_update_o,
  output logic             crc_error_o
);

  ////////////////////////////////////////////////////////////////////////////
  // crc over one byte, msb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[31] ^ d[i]) begin
        r = {r[30:0], 1'b0} ^ burst_time_plan_pkg::CRC_POLY;
      end else begin
        r = {r[30:0], 1'b0};
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  burst_time_plan_pkg::parse_state_t state_r;

  logic        en_r;
  logic [12:0] pid_r;
  logic [15:0] term_id_r;
  logic [7:0]  group_sel_r;
  logic        err_r;
  logic        ovf_r;
  logic        valid_r;
  logic        act_r;
  logic [4:0]  act_cnt_r;
  logic [15:0] sfc_act_r;
  logic [3:0]  sel_r;
  logic [15:0] ok_cnt_r;
  logic [15:0] bad_cnt_r;

  logic [2:0]  bcnt_r;
  logic [31:0] crc_r;
  logic [7:0]  group_r;
  logic [15:0] sfc_r;
  logic [4:0]  frames_left_r;
  logic [4:0]  frame_r;
  logic [10:0] ent_left_r;
  logic [2:0]  ecnt_hi_r;
  logic [15:0] tid_r;
  logic        mc_r;
  logic [1:0]  atype_r;
  logic        qe_r;
  logic [10:0] start_r;
  logic [3:0]  chan_r;
  logic [4:0]  wcnt_r;
  logic        wovf_r;

  logic [30:0] mem_r [2][burst_time_plan_pkg::ENT_DEPTH];

  logic        take;
  logic        bus_ack;
  logic [31:0] crc_nxt;
  logic        sec_last;
  logic        commit;
  logic        fail;
  logic        match;
  logic        store;
  logic        clr_err;
  logic [30:0] ent_word;
  logic [11:0] ent_last;

  ////////////////////////////////////////////////////////////////////////////
  // input qualification
  // a byte from any other identifier never reaches the parser
  assign take = ce_i & sec_valid_i & en_r & (sec_pid_i == pid_r);

  assign crc_nxt = sec_start_i ? crc_byte(burst_time_plan_pkg::CRC_INIT, sec_data_i)
                               : crc_byte(crc_r, sec_data_i);

  assign sec_last = take & ~sec_start_i & (state_r == burst_time_plan_pkg::S_CRC) &
                    (bcnt_r[1:0] == burst_time_plan_pkg::CRC_LAST_BYTE);
  assign commit   = sec_last & (crc_nxt == 32'h00000000);
  assign fail     = sec_last & (crc_nxt != 32'h00000000);

  // identifiers are only unique within a group
  assign match = (tid_r == term_id_r) & (group_r == group_sel_r);
  assign store = take & ~sec_start_i & (state_r == burst_time_plan_pkg::S_ACNT) &
                 match & (atype_r != burst_time_plan_pkg::ATYPE_RESERVED) &
                 ~wcnt_r[burst_time_plan_pkg::ENT_AW];

  // entry word: type, queue-empty, channel, frame, start, count
  assign ent_word = {atype_r, qe_r, chan_r, frame_r, start_r, sec_data_i};

  ////////////////////////////////////////////////////////////////////////////
  // crc accumulator
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      crc_r <= burst_time_plan_pkg::CRC_INIT;
    end else if (take) begin
      crc_r <= crc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // section walker
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_r       <= burst_time_plan_pkg::S_IDLE;
      bcnt_r        <= 3'h0;
      group_r       <= 8'h00;
      sfc_r         <= 16'h0000;
      frames_left_r <= 5'h00;
      frame_r       <= 5'h00;
      ent_left_r    <= 11'h000;
      ecnt_hi_r     <= 3'h0;
      tid_r         <= 16'h0000;
      mc_r          <= 1'b0;
      atype_r       <= 2'b00;
      qe_r          <= 1'b0;
      start_r       <= 11'h000;
      chan_r        <= 4'h0;
    end else if (take && sec_start_i) begin
      // a new start always resyncs, abandoning any partial section
      state_r <= burst_time_plan_pkg::S_HDR;
      bcnt_r  <= 3'h1;
    end else if (take) begin
      case (state_r)
        burst_time_plan_pkg::S_IDLE: begin
          state_r <= burst_time_plan_pkg::S_IDLE;
        end
        burst_time_plan_pkg::S_HDR: begin
          bcnt_r <= bcnt_r + 3'h1;
          if (bcnt_r == burst_time_plan_pkg::HDR_LAST_BYTE) begin
            state_r <= burst_time_plan_pkg::S_GROUP;
          end
        end
        burst_time_plan_pkg::S_GROUP: begin
          group_r <= sec_data_i;
          bcnt_r  <= 3'h0;
          state_r <= burst_time_plan_pkg::S_SFC;
        end
        burst_time_plan_pkg::S_SFC: begin
          sfc_r  <= {sfc_r[7:0], sec_data_i};
          bcnt_r <= bcnt_r + 3'h1;
          if (bcnt_r[0]) begin
            state_r <= burst_time_plan_pkg::S_FLOOP;
          end
        end
        burst_time_plan_pkg::S_FLOOP: begin
          frames_left_r <= sec_data_i[4:0];
          state_r       <= burst_time_plan_pkg::S_FNUM;
        end
        burst_time_plan_pkg::S_FNUM: begin
          frame_r <= sec_data_i[4:0];
          bcnt_r  <= 3'h0;
          state_r <= burst_time_plan_pkg::S_ECNT;
        end
        burst_time_plan_pkg::S_ECNT: begin
          bcnt_r <= bcnt_r + 3'h1;
          if (!bcnt_r[0]) begin
            ecnt_hi_r <= sec_data_i[2:0];
          end else begin
            ent_left_r <= {ecnt_hi_r, sec_data_i};
            bcnt_r     <= 3'h0;
            state_r    <= burst_time_plan_pkg::S_TID;
          end
        end
        burst_time_plan_pkg::S_TID: begin
          tid_r  <= {tid_r[7:0], sec_data_i};
          bcnt_r <= bcnt_r + 3'h1;
          if (bcnt_r[0]) begin
            state_r <= burst_time_plan_pkg::S_FLAGS;
          end
        end
        burst_time_plan_pkg::S_FLAGS: begin
          mc_r          <= sec_data_i[7];
          atype_r       <= sec_data_i[6:5];
          qe_r          <= sec_data_i[4];
          start_r[10:8] <= sec_data_i[2:0];
          chan_r        <= 4'h0;
          state_r       <= burst_time_plan_pkg::S_START;
        end
        burst_time_plan_pkg::S_START: begin
          start_r[7:0] <= sec_data_i;
          state_r      <= mc_r ? burst_time_plan_pkg::S_CHAN
                               : burst_time_plan_pkg::S_ACNT;
        end
        burst_time_plan_pkg::S_CHAN: begin
          chan_r  <= sec_data_i[3:0];
          state_r <= burst_time_plan_pkg::S_ACNT;
        end
        burst_time_plan_pkg::S_ACNT: begin
          // every entry is walked, matching or not
          bcnt_r <= 3'h0;
          if (ent_left_r != 11'h000) begin
            ent_left_r <= ent_left_r - 11'h001;
            state_r    <= burst_time_plan_pkg::S_TID;
          end else if (frames_left_r != 5'h00) begin
            frames_left_r <= frames_left_r - 5'h01;
            state_r       <= burst_time_plan_pkg::S_FNUM;
          end else begin
            state_r <= burst_time_plan_pkg::S_CRC;
          end
        end
        burst_time_plan_pkg::S_CRC: begin
          bcnt_r <= bcnt_r + 3'h1;
          if (bcnt_r[1:0] == burst_time_plan_pkg::CRC_LAST_BYTE) begin
            state_r <= burst_time_plan_pkg::S_IDLE;
          end
        end
        default: begin
          state_r <= burst_time_plan_pkg::S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // staging bank: fills the inactive half, swapped only on a good crc
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wcnt_r <= 5'h00;
      wovf_r <= 1'b0;
    end else if (take && sec_start_i) begin
      wcnt_r <= 5'h00;
      wovf_r <= 1'b0;
    end else if (store) begin
      wcnt_r <= wcnt_r + 5'h01;
    end else if (take && (state_r == burst_time_plan_pkg::S_ACNT) && match &&
                 (atype_r != burst_time_plan_pkg::ATYPE_RESERVED)) begin
      // table full; later blocks for this terminal are lost
      wovf_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (store) begin
      mem_r[~act_r][wcnt_r[burst_time_plan_pkg::ENT_AW-1:0]] <= ent_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // committed plan, error and counters
  assign clr_err = bus_ack & avs_write_i & (avs_address_i == burst_time_plan_pkg::OFS_CTRL) &
                   avs_writedata_i[burst_time_plan_pkg::CTRL_CLR_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      act_r     <= 1'b0;
      act_cnt_r <= 5'h00;
      sfc_act_r <= 16'h0000;
      valid_r   <= 1'b0;
      ovf_r     <= 1'b0;
      err_r     <= 1'b0;
      ok_cnt_r  <= 16'h0000;
      bad_cnt_r <= 16'h0000;
    end else if (ce_i) begin
      if (commit) begin
        act_r     <= ~act_r;
        act_cnt_r <= wcnt_r;
        sfc_act_r <= sfc_r;
        valid_r   <= 1'b1;
        ovf_r     <= wovf_r;
        ok_cnt_r  <= ok_cnt_r + 16'h0001;
      end
      if (fail) begin
        bad_cnt_r <= bad_cnt_r + 16'h0001;
      end
      // a failure in the clearing cycle still sets the flag
      err_r <= fail | (err_r & ~clr_err);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      plan_update_o <= 1'b0;
      crc_error_o   <= 1'b0;
    end else if (ce_i) begin
      plan_update_o <= commit;
      crc_error_o   <= fail | (err_r & ~clr_err);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait cycle, then ack
  assign bus_ack  = ce_i & (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  assign ent_last = {1'b0, mem_r[act_r][sel_r][18:8]} + {4'h0, mem_r[act_r][sel_r][7:0]};

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      en_r        <= burst_time_plan_pkg::CTRL_EN_RST;
      pid_r       <= burst_time_plan_pkg::PID_RST;
      term_id_r   <= burst_time_plan_pkg::TERM_ID_RST;
      group_sel_r <= burst_time_plan_pkg::GROUP_RST;
      sel_r       <= 4'h0;
    end else if (bus_ack && avs_write_i) begin
      case (avs_address_i)
        burst_time_plan_pkg::OFS_CTRL: begin
          en_r <= avs_writedata_i[burst_time_plan_pkg::CTRL_EN_BIT];
        end
        burst_time_plan_pkg::OFS_PID: begin
          pid_r <= avs_writedata_i[12:0];
        end
        burst_time_plan_pkg::OFS_TERM: begin
          term_id_r   <= avs_writedata_i[15:0];
          group_sel_r <= avs_writedata_i[burst_time_plan_pkg::TERM_GROUP_LSB +: 8];
        end
        burst_time_plan_pkg::OFS_ENT_SEL: begin
          sel_r <= avs_writedata_i[3:0];
        end
        default: begin
          sel_r <= sel_r;
        end
      endcase
    end
  end

  // read data prepared while waitrequest drops, so it stands at the ack edge
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (ce_i && avs_read_i && avs_waitrequest_o) begin
      case (avs_address_i)
        burst_time_plan_pkg::OFS_CTRL:     avs_readdata_o <= {31'h00000000, en_r};
        burst_time_plan_pkg::OFS_PID:      avs_readdata_o <= {19'h00000, pid_r};
        burst_time_plan_pkg::OFS_TERM:     avs_readdata_o <= {8'h00, group_sel_r, term_id_r};
        burst_time_plan_pkg::OFS_STATUS: begin
          avs_readdata_o <= {19'h00000, act_cnt_r, 4'h0, ovf_r, valid_r, err_r,
                             (state_r != burst_time_plan_pkg::S_IDLE)};
        end
        burst_time_plan_pkg::OFS_SUPERFRM: avs_readdata_o <= {16'h0000, sfc_act_r};
        burst_time_plan_pkg::OFS_ENT_SEL:  avs_readdata_o <= {28'h0000000, sel_r};
        burst_time_plan_pkg::OFS_ENT_DATA: avs_readdata_o <= {1'b0, mem_r[act_r][sel_r]};
        burst_time_plan_pkg::OFS_ENT_LAST: avs_readdata_o <= {20'h00000, ent_last};
        burst_time_plan_pkg::OFS_SEC_CNT:  avs_readdata_o <= {bad_cnt_r, ok_cnt_r};
        default:                           avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

endmodule // burst_time_plan_parser

/* File: burst_time_plan_parser_tb.sv */
`timescale 1ns/100ps
module burst_time_plan_parser_tb;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        ce_i = 1'b1;
  logic [5:0]  avs_address_i = 6'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o, rd;
  logic        avs_waitrequest_o, plan_update_o, crc_error_o, sec_valid_i, sec_start_i;
  logic [7:0]  sec_data_i, my_grp, cur_grp;
  logic [12:0] sec_pid_i, pid;
  logic [15:0] seed = 16'h000b;
  logic [15:0] my_tid, cur_sfc, good_sfc, r, s;
  logic [4:0]  cur_fr;
  logic        last_bad = 1'b0;
  logic [31:0] ew[$], gw[$];
  int          mismatches = 0, samples_checked = 0, upd = 0, n_good = 0, n_bad = 0;

  burst_time_plan_parser DUT (.sys_clk_i, .rst_n_i, .ce_i, .sec_data_i, .sec_valid_i,
    .sec_start_i, .sec_pid_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .plan_update_o, .crc_error_o);
  nc_section_source src (.sys_clk_i, .sec_data_o(sec_data_i), .sec_valid_o(sec_valid_i),
    .sec_start_o(sec_start_i), .sec_pid_o(sec_pid_i));

  initial forever #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (plan_update_o === 1'b1) upd <= upd + 1;
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    if (avs_waitrequest_o !== 1'b0) begin
      check("waitrequest", 32'h0, 32'h1);
      test_done();
    end
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    check(nm, e, rd);
  endtask
  task automatic open(input logic [7:0] g, input logic [15:0] sf, input logic [4:0] nf);
    ew.delete();
    cur_grp = g;
    cur_sfc = sf;
    src.open_sec(g, sf, nf);
  endtask
  task automatic frm(input logic [4:0] f, input logic [10:0] c);
    cur_fr = f;
    src.frame(f, c);
  endtask
  task automatic ent(input logic [15:0] t, input logic mc, input logic [1:0] ty,
                     input logic qe, input logic [10:0] st, input logic [3:0] ch,
                     input logic [7:0] n);
    src.entry(t, mc, ty, qe, st, ch, n);
    if (t == my_tid && cur_grp == my_grp && ty != 2'b11 && ew.size() < 16)
      ew.push_back({1'b0, ty, qe, mc ? ch : 4'h0, cur_fr, st, n});
  endtask
  // a commit is only expected for a good section on the right identifier
  task automatic run(input logic [12:0] p, input int gap, input logic bad, input logic eu);
    int u0;
    u0 = upd;
    src.close_sec(bad);
    src.send(p, gap);
    repeat (4) @(posedge sys_clk_i);
    check("plan_update", 32'(eu), 32'(upd - u0));
    check("crc_error", 32'(bad), 32'(crc_error_o));
    if (eu) begin
      gw = ew;
      good_sfc = cur_sfc;
      n_good++;
    end
    n_bad = n_bad + int'(bad);
    last_bad = bad;
  endtask
  task automatic verify(input logic ovf);
    bus(1'b0, 6'h0c, 32'h0);
    check("plan_count", 32'(gw.size()), 32'(rd[12:8]));
    check("overflow", 32'(ovf), 32'(rd[3]));
    check("status_flags", {29'h0, 1'b1, last_bad, 1'b0}, 32'(rd[2:0]));
    rdc(6'h10, 32'(good_sfc), "superframe");
    foreach (gw[i]) begin
      bus(1'b1, 6'h14, 32'(i));
      rdc(6'h18, gw[i], "entry");
      rdc(6'h1c, 32'(gw[i][18:8]) + 32'(gw[i][7:0]), "last_slot");
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rdc(6'h00, 32'h0, "ctrl");
    rdc(6'h04, 32'h1fff, "pid");
    rdc(6'h08, 32'h0, "term");
    rdc(6'h0c, 32'h0, "status");
    bus(1'b1, 6'h3c, 32'hffffffff);
    rdc(6'h3c, 32'h0, "unmapped");
    r = rnd();
    my_tid = rnd();
    my_grp = r[7:0];
    pid = 13'(rnd());
    bus(1'b1, 6'h04, 32'(pid));
    bus(1'b1, 6'h08, {8'h00, my_grp, my_tid});
    bus(1'b1, 6'h00, 32'h1);
    rdc(6'h08, {8'h00, my_grp, my_tid}, "term");
    $display("test registers done");
    open(my_grp, 16'hffff, 5'h01);
    frm(5'h1f, 11'h004);
    ent(my_tid, 1'b0, 2'b00, 1'b1, 11'h7ff, 4'h9, 8'hff);
    ent(my_tid ^ 16'h0001, 1'b0, 2'b01, 1'b0, 11'h000, 4'h0, 8'h00);
    ent(my_tid, 1'b1, 2'b01, 1'b0, 11'h123, 4'hf, 8'h00);
    ent(my_tid, 1'b1, 2'b11, 1'b1, 11'h005, 4'h3, 8'h01);
    ent(my_tid, 1'b0, 2'b10, 1'b0, 11'h010, 4'h0, 8'h07);
    frm(5'h00, 11'h000);
    ent(my_tid, 1'b1, 2'b00, 1'b1, 11'h001, 4'h0, 8'h02);
    run(pid, 0, 1'b0, 1'b1);
    verify(1'b0);
    $display("test corner section done");
    open(my_grp, 16'h1234, 5'h00);
    frm(5'h03, 11'h000);
    ent(my_tid, 1'b0, 2'b01, 1'b0, 11'h020, 4'h0, 8'h03);
    run(pid, 1, 1'b1, 1'b0);
    verify(1'b0);
    bus(1'b1, 6'h00, 32'h3);
    check("crc_clear", 32'h0, 32'(crc_error_o));
    $display("test bad crc done");
    open(my_grp, 16'h0042, 5'h00);
    frm(5'h02, 11'h000);
    ent(my_tid, 1'b0, 2'b00, 1'b0, 11'h040, 4'h0, 8'h01);
    run(pid ^ 13'h0001, 0, 1'b0, 1'b0);
    bus(1'b1, 6'h00, 32'h0);
    run(pid, 0, 1'b0, 1'b0);
    bus(1'b1, 6'h00, 32'h1);
    // frozen clock enable: a good section must leave no trace
    ce_i <= 1'b0;
    run(pid, 0, 1'b0, 1'b0);
    ce_i <= 1'b1;
    verify(1'b0);
    $display("test filter done");
    // section cut before its crc, then aborted by the next start
    open(my_grp, 16'h0300, 5'h00);
    frm(5'h01, 11'h001);
    ent(my_tid, 1'b0, 2'b00, 1'b0, 11'h060, 4'h0, 8'h01);
    ent(my_tid, 1'b1, 2'b01, 1'b1, 11'h070, 4'h2, 8'h02);
    src.send(pid, 0);
    bus(1'b0, 6'h0c, 32'h0);
    check("busy", 32'h1, 32'(rd[0]));
    open(my_grp ^ 8'h01, 16'h0100, 5'h00);
    frm(5'h02, 11'h000);
    ent(my_tid, 1'b0, 2'b00, 1'b0, 11'h050, 4'h0, 8'h01);
    run(pid, 0, 1'b0, 1'b1);
    verify(1'b0);
    open(my_grp, 16'h0200, 5'h00);
    frm(5'h04, 11'd16);
    for (int i = 0; i < 17; i++) ent(my_tid, 1'b0, 2'b01, 1'b1, 11'(i), 4'h0, 8'(i));
    run(pid, 0, 1'b0, 1'b1);
    verify(1'b1);
    $display("test group and overflow done");
    for (int k = 0; k < 6; k++) begin
      s = rnd();
      open(my_grp, rnd(), 5'(s[0]));
      for (int f = 0; f <= int'(s[0]); f++) begin
        frm(5'(f + 7), 11'(s[3:2]));
        for (int e = 0; e <= int'(s[3:2]); e++) begin
          r = rnd();
          ent(r[0] ? my_tid : rnd(), r[1], r[3:2], r[4], 11'(rnd()), r[11:8], r[15:8]);
        end
      end
      run(pid, int'(s[5:4]), 1'b0, 1'b1);
      verify(1'b0);
    end
    $display("test random done");
    rdc(6'h20, {16'(n_bad), 16'(n_good)}, "section_counts");
    test_done();
  end
endmodule // burst_time_plan_parser_tb

/* File: burst_time_plan_pkg.sv */
package burst_time_plan_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [5:0] OFS_CTRL      = 6'h00;
  localparam logic [5:0] OFS_PID       = 6'h04;
  localparam logic [5:0] OFS_TERM      = 6'h08;
  localparam logic [5:0] OFS_STATUS    = 6'h0c;
  localparam logic [5:0] OFS_SUPERFRM  = 6'h10;
  localparam logic [5:0] OFS_ENT_SEL   = 6'h14;
  localparam logic [5:0] OFS_ENT_DATA  = 6'h18;
  localparam logic [5:0] OFS_ENT_LAST  = 6'h1c;
  localparam logic [5:0] OFS_SEC_CNT   = 6'h20;

  // field positions
  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_CLR_BIT     = 1;
  localparam int ST_BUSY_BIT      = 0;
  localparam int ST_ERR_BIT       = 1;
  localparam int ST_VALID_BIT     = 2;
  localparam int ST_OVF_BIT       = 3;
  localparam int ST_CNT_LSB       = 8;
  localparam int TERM_GROUP_LSB   = 16;

  // reset values
  localparam logic        CTRL_EN_RST = 1'b0;
  localparam logic [12:0] PID_RST     = 13'h1fff;
  localparam logic [15:0] TERM_ID_RST = 16'h0000;
  localparam logic [7:0]  GROUP_RST   = 8'h00;

  // section layout
  localparam logic [2:0]  HDR_LAST_BYTE = 3'h7;
  localparam logic [1:0]  CRC_LAST_BYTE = 2'h3;
  localparam logic [31:0] CRC_INIT      = 32'hffffffff;
  localparam logic [31:0] CRC_POLY      = 32'h04c11db7;

  // assignment types
  localparam logic [1:0] ATYPE_ONCE     = 2'b00;
  localparam logic [1:0] ATYPE_REPEAT   = 2'b01;
  localparam logic [1:0] ATYPE_RELEASE  = 2'b10;
  localparam logic [1:0] ATYPE_RESERVED = 2'b11;

  // stored entries per bank
  localparam int ENT_DEPTH = 16;
  localparam int ENT_AW    = 4;

  typedef enum logic [12:0] {
    S_IDLE  = 13'h0001,
    S_HDR   = 13'h0002,
    S_GROUP = 13'h0004,
    S_SFC   = 13'h0008,
    S_FLOOP = 13'h0010,
    S_FNUM  = 13'h0020,
    S_ECNT  = 13'h0040,
    S_TID   = 13'h0080,
    S_FLAGS = 13'h0100,
    S_START = 13'h0200,
    S_CHAN  = 13'h0400,
    S_ACNT  = 13'h0800,
    S_CRC   = 13'h1000
  } parse_state_t;

endpackage

/* File: burst_time_plan_properties.sv */
`timescale 1ns/100ps
module burst_time_plan_checker (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  // stream and bus
  input wire logic        sec_valid_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic        avs_waitrequest_o,
  // status
  input wire logic        plan_update_o,
  input wire logic        crc_error_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire req = avs_read_i | avs_write_i;
  // clear acts only at the acknowledged edge
  wire clr = avs_write_i && !avs_waitrequest_o && avs_address_i == 6'h00 &&
             avs_writedata_i[1];
  //////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_n_i |=> avs_waitrequest_o && !plan_update_o && !crc_error_o)
    else $error("reset values wrong");
  a_update_pulse: assert property (plan_update_o |=> !plan_update_o)
    else $error("plan update longer than one cycle");
  a_update_cause: assert property (plan_update_o |-> $past(sec_valid_i) ||
    $past(sec_valid_i, 2)) else $error("plan update without a byte");
  a_update_vs_err: assert property (plan_update_o |-> !$rose(crc_error_o))
    else $error("commit and crc error together");
  a_error_sticky: assert property (crc_error_o && !clr |=> crc_error_o)
    else $error("crc error dropped without clear");
  a_error_cause: assert property ($rose(crc_error_o) |-> $past(sec_valid_i) ||
    $past(sec_valid_i, 2)) else $error("crc error without a byte");
  a_wait_answer: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("no answer one cycle after request");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!req ##1 !req |-> avs_waitrequest_o)
    else $error("waitrequest low while idle");
  c_commit: cover property (plan_update_o);
  c_error: cover property ($rose(crc_error_o));
  c_clear: cover property (clr && !avs_waitrequest_o);
  c_access: cover property (req && !avs_waitrequest_o);
endmodule // burst_time_plan_checker

bind burst_time_plan_parser burst_time_plan_checker chk (.sys_clk_i, .rst_n_i, .sec_valid_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o,
  .plan_update_o, .crc_error_o);

/* File: nc_section_source.sv */
`timescale 1ns/100ps
module nc_section_source (
  // clock
  input  wire logic        sys_clk_i,
  // section byte stream
  output logic      [7:0]  sec_data_o,
  output logic             sec_valid_o,
  output logic             sec_start_o,
  output logic      [12:0] sec_pid_o
);
  logic [7:0] q[$];
  initial begin
    sec_data_o = 8'h5a;
    sec_valid_o = 1'b0;
    sec_start_o = 1'b0;
    sec_pid_o = 13'h0000;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic open_sec(input logic [7:0] g, input logic [15:0] s, input logic [4:0] nf);
    q.delete();
    for (int i = 0; i < 8; i++) q.push_back(8'h30 + 8'(i));
    q.push_back(g);
    q.push_back(s[15:8]);
    q.push_back(s[7:0]);
    // reserved bits sent as ones; the parser must ignore them
    q.push_back({3'h7, nf});
  endtask
  task automatic frame(input logic [4:0] f, input logic [10:0] c);
    q.push_back({3'h7, f});
    q.push_back({5'h1f, c[10:8]});
    q.push_back(c[7:0]);
  endtask
  task automatic entry(input logic [15:0] t, input logic mc, input logic [1:0] ty,
                       input logic qe, input logic [10:0] st, input logic [3:0] ch,
                       input logic [7:0] n);
    q.push_back(t[15:8]);
    q.push_back(t[7:0]);
    q.push_back({mc, ty, qe, 1'b1, st[10:8]});
    q.push_back(st[7:0]);
    if (mc) q.push_back({4'hf, ch});
    q.push_back(n);
  endtask
  // bad flips one crc bit so the residue is no longer zero
  task automatic close_sec(input logic bad);
    logic [31:0] c;
    c = burst_time_plan_pkg::CRC_INIT;
    foreach (q[i]) for (int b = 7; b >= 0; b--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ q[i][b]) ? burst_time_plan_pkg::CRC_POLY : 32'h0);
    c[0] = c[0] ^ bad;
    for (int k = 3; k >= 0; k--) q.push_back(c[8*k +: 8]);
  endtask
  task automatic send(input logic [12:0] pid, input int gap);
    foreach (q[i]) begin
      @(posedge sys_clk_i);
      sec_pid_o <= pid;
      sec_data_o <= q[i];
      sec_valid_o <= 1'b1;
      sec_start_o <= (i == 0);
      repeat (gap) begin
        @(posedge sys_clk_i);
        sec_valid_o <= 1'b0;
        sec_start_o <= 1'b0;
        sec_data_o <= ~q[i];
      end
    end
    @(posedge sys_clk_i);
    sec_valid_o <= 1'b0;
    sec_start_o <= 1'b0;
    sec_data_o <= ~q[q.size()-1];
  endtask
endmodule // nc_section_source
